// file: hdl/ltf_tx_assembly.sv
module ltf_tx_assembly
  import ltf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ltf_cfg_type cfg,
  input wire ltf_cmd_type cmd,
  input wire logic cmd_start,
  input wire logic link_busy,
  input wire logic collision_detect_input,
  input wire logic collision,
  input wire logic data_underrun,
  input wire logic cts_lost,
  input wire logic crs_lost,
  input wire logic cu_abort,
  input wire logic bit_tick,
  input wire logic frame_last_bits,
  input wire logic frame_done,
  output logic tx_active,
  output logic jam_active,
  output logic insert_src_addr,
  output ltf_src_type first_src,
  output logic [7:0] block_ofs,
  output logic [13:0] block_len,
  output logic use_desc,
  output logic [31:0] desc_addr,
  output logic dest_group,
  output logic dest_broadcast,
  output logic [15:0] len_wire_order,
  output logic [15:0] status_word,
  output logic status_write
);

  // ****************************************************
  // state
  // ****************************************************
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_DEFER = 3'b001,
    ST_PRE = 3'b010,
    ST_SEND = 3'b011,
    ST_JAM = 3'b100,
    ST_DONE = 3'b101
  } ltf_state_type;

  ltf_state_type state_ff, nxt_state;
  logic [15:0] stat_ff, nxt_stat;
  logic [4:0] coll_ff, nxt_coll;
  logic [6:0] pre_ff, nxt_pre;
  logic [5:0] jam_ff, nxt_jam;
  logic heart_ff, nxt_heart;
  logic abort_pend_ff, nxt_abort_pend;
  logic wr_ff, nxt_wr;
  logic jam_out_ff, nxt_jam_out;
  logic act_ff, nxt_act;
  logic ins_ff, nxt_ins;
  ltf_src_type src_ff, nxt_src;
  logic [7:0] ofs_ff, nxt_ofs;
  logic [13:0] blen_ff, nxt_blen;
  logic udesc_ff, nxt_udesc;
  logic [31:0] daddr_ff, nxt_daddr;
  logic grp_ff, nxt_grp;
  logic bc_ff, nxt_bc;
  logic [15:0] lwo_ff, nxt_lwo;
  logic [14:0] size_est;
  logic short_frame;
  logic abort_any;

  // ****************************************************
  // frame layout decisions
  // ****************************************************
  always_comb
  begin
    nxt_ins = ~cfg.no_src_insert & ~cfg.addr_in_data;
    nxt_ofs = (cfg.mode == MODE_LINEAR) ? LIN_BLOCK_OFS : SEG_BLOCK_OFS;
    nxt_blen = (cfg.mode == MODE_LEGACY) ? COUNT_ZERO
      : cmd.command_byte_count;
    if (cfg.mode == MODE_LEGACY)
      nxt_src = SRC_BUFFER;
    else if (!cfg.flexible_model_flag)
      nxt_src = SRC_BLOCK;
    else if (cmd.command_byte_count != COUNT_ZERO)
      nxt_src = SRC_BLOCK;
    else
      nxt_src = SRC_BUFFER;
    nxt_udesc = (cmd.desc_ptr != NO_DESC_PTR);
    // legacy and segmented pointers are offsets, linear is a full address
    nxt_daddr = (cfg.mode == MODE_LINEAR) ? cmd.desc_ptr
      : {16'h0000, cmd.desc_ptr[15:0]};
    nxt_grp = cmd.dest_addr[0];
    nxt_bc = &cmd.dest_addr;
    nxt_lwo = cmd.length_field;
    if (state_ff != ST_IDLE || !cmd_start)
    begin
      nxt_ins = ins_ff;
      nxt_ofs = ofs_ff;
      nxt_blen = blen_ff;
      nxt_src = src_ff;
      nxt_udesc = udesc_ff;
      nxt_daddr = daddr_ff;
      nxt_grp = grp_ff;
      nxt_bc = bc_ff;
      nxt_lwo = lwo_ff;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ins_ff <= 1'b0;
      src_ff <= SRC_NONE;
      ofs_ff <= 8'h00;
      blen_ff <= 14'h0000;
      udesc_ff <= 1'b0;
      daddr_ff <= 32'h0000_0000;
      grp_ff <= 1'b0;
      bc_ff <= 1'b0;
      lwo_ff <= 16'h0000;
    end
    else
    begin
      ins_ff <= nxt_ins;
      src_ff <= nxt_src;
      ofs_ff <= nxt_ofs;
      blen_ff <= nxt_blen;
      udesc_ff <= nxt_udesc;
      daddr_ff <= nxt_daddr;
      grp_ff <= nxt_grp;
      bc_ff <= nxt_bc;
      lwo_ff <= nxt_lwo;
    end
  end

  // ****************************************************
  // transmit sequence and status
  // ****************************************************
  // size estimate counts only block bytes plus first buffer; chained
  // buffers beyond the first are not seen here
  assign size_est = (cfg.mode == MODE_LEGACY) ? {1'b0, cmd.first_buf_count}
    : ({1'b0, cmd.command_byte_count} + {1'b0, cmd.first_buf_count});
  assign short_frame = (size_est < {11'h000, MIN_FRAME_BYTES});
  assign abort_any = data_underrun | cts_lost | crs_lost | cu_abort;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_stat = stat_ff;
    nxt_coll = coll_ff;
    nxt_pre = pre_ff;
    nxt_jam = jam_ff;
    nxt_abort_pend = abort_pend_ff;
    nxt_wr = 1'b0;
    nxt_heart = heart_ff;
    // heartbeat watched only in the gap between frames
    if (state_ff == ST_IDLE || state_ff == ST_DEFER)
      nxt_heart = heart_ff | collision_detect_input;
    unique case (state_ff)
      ST_IDLE:
        if (cmd_start)
        begin
          nxt_stat = STATUS_RESET;
          nxt_coll = 5'h00;
          nxt_abort_pend = 1'b0;
          if (cfg.mode == MODE_LEGACY && short_frame)
          begin
            nxt_stat[BIT_UNDERRUN] = 1'b1;
            nxt_state = ST_DONE;
          end
          else if (link_busy)
          begin
            nxt_stat[BIT_DEFER] = 1'b1;
            nxt_state = ST_DEFER;
          end
          else
          begin
            nxt_pre = 7'h00;
            nxt_state = ST_PRE;
          end
        end
      ST_DEFER:
        if (!link_busy)
        begin
          nxt_pre = 7'h00;
          nxt_state = ST_PRE;
        end
      ST_PRE:
      begin
        if (collision || abort_any)
          nxt_abort_pend = 1'b1;
        if (collision)
          nxt_coll = coll_ff + 5'h01;
        if (data_underrun)
          nxt_stat[BIT_UNDERRUN] = 1'b1;
        if (cts_lost)
          nxt_stat[BIT_NOCTS] = 1'b1;
        if (cu_abort)
          nxt_stat[BIT_ABORT] = 1'b1;
        if (bit_tick)
          nxt_pre = pre_ff + 7'h01;
        if (bit_tick && pre_ff == PREAMBLE_BITS - 7'h01)
        begin
          nxt_jam = 6'h00;
          // jam held back until the preamble is out
          nxt_state = (abort_pend_ff || collision || abort_any)
            ? ST_JAM : ST_SEND;
        end
      end
      ST_SEND:
        if (abort_any || (collision && !frame_last_bits))
        begin
          // late collisions in the tail are ignored
          if (collision)
            nxt_coll = coll_ff + 5'h01;
          nxt_stat[BIT_UNDERRUN] = stat_ff[BIT_UNDERRUN] | data_underrun;
          nxt_stat[BIT_NOCTS] = stat_ff[BIT_NOCTS] | cts_lost;
          nxt_stat[BIT_NOCRS] = stat_ff[BIT_NOCRS] | crs_lost;
          nxt_stat[BIT_ABORT] = stat_ff[BIT_ABORT] | cu_abort;
          nxt_jam = 6'h00;
          nxt_state = ST_JAM;
        end
        else if (frame_done)
        begin
          nxt_stat[BIT_OK] = 1'b1;
          nxt_state = ST_DONE;
        end
      ST_JAM:
        if (bit_tick && jam_ff == JAM_BITS - 6'h01)
        begin
          if (stat_ff[BIT_UNDERRUN] || stat_ff[BIT_NOCTS]
              || stat_ff[BIT_NOCRS] || stat_ff[BIT_ABORT])
            nxt_state = ST_DONE;
          else if (coll_ff > {1'b0, cfg.max_retry})
          begin
            nxt_stat[BIT_RETRY] = 1'b1;
            nxt_state = ST_DONE;
          end
          else
          begin
            nxt_pre = 7'h00;
            nxt_abort_pend = 1'b0;
            nxt_state = ST_PRE;
          end
        end
        else if (bit_tick)
          nxt_jam = jam_ff + 6'h01;
      ST_DONE:
      begin
        nxt_stat[3:0] = coll_ff[3:0];
        nxt_stat[4] = 1'b0;
        nxt_stat[BIT_HEART] = heart_ff;
        // a beat in the write-back cycle already belongs to the next gap
        nxt_heart = collision_detect_input;
        nxt_wr = 1'b1;
        nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    nxt_jam_out = (nxt_state == ST_JAM);
    nxt_act = (nxt_state == ST_PRE) || (nxt_state == ST_SEND)
      || (nxt_state == ST_JAM);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      stat_ff <= STATUS_RESET;
      coll_ff <= 5'h00;
      pre_ff <= 7'h00;
      jam_ff <= 6'h00;
      heart_ff <= 1'b0;
      abort_pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      jam_out_ff <= 1'b0;
      act_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      stat_ff <= nxt_stat;
      coll_ff <= nxt_coll;
      pre_ff <= nxt_pre;
      jam_ff <= nxt_jam;
      heart_ff <= nxt_heart;
      abort_pend_ff <= nxt_abort_pend;
      wr_ff <= nxt_wr;
      jam_out_ff <= nxt_jam_out;
      act_ff <= nxt_act;
    end
  end

  assign tx_active = act_ff;
  assign jam_active = jam_out_ff;
  assign insert_src_addr = ins_ff;
  assign first_src = src_ff;
  assign block_ofs = ofs_ff;
  assign block_len = blen_ff;
  assign use_desc = udesc_ff;
  assign desc_addr = daddr_ff;
  assign dest_group = grp_ff;
  assign dest_broadcast = bc_ff;
  assign len_wire_order = lwo_ff;
  assign status_word = stat_ff;
  assign status_write = wr_ff;

endmodule : ltf_tx_assembly

// file: hdl/ltf_pkg.sv
// Notes on behaviour
// - status bit 7 set when transmission deferred by earlier link activity.
// - status bit 6 set if collision input seen active during interframe gap.
// - abort attempt and set bit 5 when collisions exceed retry limit.
// - four-bit collision count; zero with bit 5 means 16; bit 4 zero.
// - descriptor pointer is offset, or full address in linear; all ones none.
// - lowest destination bit marks group address; all ones is broadcast.
// - two-byte length field sent in memory order, high byte first.
// - send command byte count bytes from n+12 or N+16; ignored legacy.
// - with insertion enabled the device adds its own source address.
// - legacy or simplified model take destination and length from command block.
// - flexible model takes header from block or chain per command byte count.
// - address-in-data set: no insertion, header bytes sent unchanged.
// - first byte: legacy first buffer; simplified block; flexible block if count>0.
// - frames under six bytes invalid; legacy aborts with underrun.
// - jam any frame aborted mid-transmission for status bits 8, 9, 10, 12.
// - no jam begins before the preamble has completed.
// - no jam for collision during the final 11 bits.
package ltf_pkg;

  // ****************************************************
  // address modes and frame sources
  // ****************************************************
  typedef enum logic [1:0]
  {
    MODE_LEGACY = 2'b00,
    MODE_SEGMENTED = 2'b01,
    MODE_LINEAR = 2'b10
  } ltf_mode_type;

  typedef enum logic [1:0]
  {
    SRC_NONE = 2'b00,
    SRC_BLOCK = 2'b01,
    SRC_BUFFER = 2'b10
  } ltf_src_type;

  // ****************************************************
  // constants
  // ****************************************************
  localparam int unsigned BIT_DEFER = 7;
  localparam int unsigned BIT_HEART = 6;
  localparam int unsigned BIT_RETRY = 5;
  localparam int unsigned BIT_UNDERRUN = 8;
  localparam int unsigned BIT_NOCTS = 9;
  localparam int unsigned BIT_NOCRS = 10;
  localparam int unsigned BIT_ABORT = 12;
  localparam int unsigned BIT_OK = 13;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [31:0] NO_DESC_PTR = 32'hFFFF_FFFF;
  localparam logic [7:0] SEG_BLOCK_OFS = 8'h0C;
  localparam logic [7:0] LIN_BLOCK_OFS = 8'h10;
  localparam logic [3:0] MIN_FRAME_BYTES = 4'h6;
  localparam logic [3:0] TAIL_BITS = 4'hB;
  localparam logic [6:0] PREAMBLE_BITS = 7'h40;
  localparam logic [5:0] JAM_BITS = 6'h20;
  localparam logic [13:0] COUNT_ZERO = 14'h0000;

  // ****************************************************
  // grouped signals
  // ****************************************************
  typedef struct packed
  {
    ltf_mode_type mode;
    logic flexible_model_flag;
    logic no_src_insert;
    logic addr_in_data;
    logic [3:0] max_retry;
  } ltf_cfg_type;

  typedef struct packed
  {
    logic [31:0] desc_ptr;
    logic [13:0] command_byte_count;
    logic [47:0] dest_addr;
    logic [15:0] length_field;
    logic [13:0] first_buf_count;
  } ltf_cmd_type;

endpackage : ltf_pkg

// file: bench/ltf_tx_monitor.sv
module ltf_tx_monitor
  import ltf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ltf_cfg_type cfg,
  input wire ltf_cmd_type cmd,
  input wire logic collision,
  input wire logic frame_last_bits,
  input wire logic tx_active,
  input wire logic jam_active,
  input wire logic insert_src_addr,
  input wire logic [7:0] block_ofs,
  input wire logic use_desc,
  input wire logic dest_group,
  input wire logic dest_broadcast,
  input wire logic [15:0] len_wire_order,
  input wire logic [15:0] status_word,
  input wire logic status_write
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // checks
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // cfg and cmd stay put for a whole command, so they can be read late
  sequence s_start;
    $rose(tx_active);
  endsequence
  status_pulse_a:
    assert property (status_write |=> !status_write)
    else $error("status pulse too long");
  rsvd_zero_a:
    assert property (status_write |-> !status_word[4])
    else $error("reserved status bit set");
  retry_count_a:
    assert property (status_write && status_word[5] |->
      status_word[3:0] == 4'(cfg.max_retry + 4'h1) && !status_word[13])
    else $error("retry stop status wrong");
  dest_kind_a:
    assert property (s_start |-> dest_group == cmd.dest_addr[0] &&
      dest_broadcast == (&cmd.dest_addr))
    else $error("dest kind wrong");
  desc_use_a:
    assert property (s_start |-> use_desc == (cmd.desc_ptr != NO_DESC_PTR))
    else $error("desc use wrong");
  len_order_a:
    assert property (s_start |-> len_wire_order == cmd.length_field)
    else $error("length order wrong");
  block_ofs_a:
    assert property (s_start |-> block_ofs == (cfg.mode == MODE_LINEAR ?
      LIN_BLOCK_OFS : SEG_BLOCK_OFS))
    else $error("block offset wrong");
  src_insert_a:
    assert property (s_start |->
      insert_src_addr == !(cfg.no_src_insert || cfg.addr_in_data))
    else $error("source insert wrong");
  jam_inside_a:
    assert property (jam_active |-> tx_active)
    else $error("jam outside transmit");
  jam_wait_a:
    assert property (s_start |-> !jam_active [*8])
    else $error("jam inside preamble");
  tail_col_a:
    assert property (collision && frame_last_bits && !jam_active |=>
      !jam_active [*2])
    else $error("jam on tail collision");
endmodule : ltf_tx_monitor

// file: bench/ltf_link_model.sv
module ltf_link_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tx_active,
  input wire logic jam_active,
  input wire logic [1:0] col_mode,
  output logic bit_tick,
  output logic frame_last_bits,
  output logic frame_done,
  output logic collision
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // transceiver side
  // ****
  // one bit per clock keeps runs short; no ticks off-frame
  localparam int LAST = 264;
  int pos_ff;
  logic run;
  assign run = tx_active && !jam_active;
  assign bit_tick = tx_active;
  always_ff @(posedge sys_clk)
    if (rst || !run)
      pos_ff <= 0;
    else if (pos_ff <= LAST)
      pos_ff <= pos_ff + 1;
  assign frame_done = run && pos_ff == LAST;
  assign frame_last_bits = run && pos_ff >= LAST - 11 && pos_ff < LAST;
  assign collision = run && (col_mode == 2'h1 && pos_ff == 100 ||
    col_mode == 2'h2 && pos_ff == LAST - 5);
endmodule : ltf_link_model

// file: bench/tb_lan_transmit_frame_assembly.sv
module tb_lan_transmit_frame_assembly
  import ltf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  ltf_cfg_type cfg = '0;
  ltf_cmd_type cmd = '0;
  logic cmd_start = 1'b0;
  logic link_busy = 1'b0;
  logic collision_detect_input = 1'b0;
  logic data_underrun = 1'b0;
  logic cts_lost = 1'b0;
  logic crs_lost = 1'b0;
  logic cu_abort = 1'b0;
  logic [1:0] col_mode = 2'h0;
  logic bit_tick, frame_last_bits, frame_done, collision;
  logic tx_active, jam_active, insert_src_addr, use_desc;
  logic dest_group, dest_broadcast, status_write;
  ltf_src_type first_src;
  logic [7:0] block_ofs;
  logic [13:0] block_len;
  logic [31:0] desc_addr;
  logic [15:0] len_wire_order, status_word, rnd = 16'h1340;
  logic [47:0] r;
  int bad_count = 0;
  int total_checks = 0;
  ltf_tx_assembly u_ltf_tx_assembly
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg),
    .cmd(cmd),
    .cmd_start(cmd_start),
    .link_busy(link_busy),
    .collision_detect_input(collision_detect_input),
    .collision(collision),
    .data_underrun(data_underrun),
    .cts_lost(cts_lost),
    .crs_lost(crs_lost),
    .cu_abort(cu_abort),
    .bit_tick(bit_tick),
    .frame_last_bits(frame_last_bits),
    .frame_done(frame_done),
    .tx_active(tx_active),
    .jam_active(jam_active),
    .insert_src_addr(insert_src_addr),
    .first_src(first_src),
    .block_ofs(block_ofs),
    .block_len(block_len),
    .use_desc(use_desc),
    .desc_addr(desc_addr),
    .dest_group(dest_group),
    .dest_broadcast(dest_broadcast),
    .len_wire_order(len_wire_order),
    .status_word(status_word),
    .status_write(status_write)
  );
  ltf_link_model u_ltf_link_model
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .tx_active(tx_active),
    .jam_active(jam_active),
    .col_mode(col_mode),
    .bit_tick(bit_tick),
    .frame_last_bits(frame_last_bits),
    .frame_done(frame_done),
    .collision(collision)
  );
  always #5 sys_clk = ~sys_clk;
  // ****
  // helpers
  // ****
  function automatic logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lf
  task automatic chk(input string nm, input logic [63:0] s,
    input logic [63:0] e);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %0h got %0h", nm, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // k: 0 plain, 1-4 abort cause, 5 retry, 6 tail hit, 7 defer, 8 beat
  task automatic go(input int k);
    int n;
    logic seen, lay, lg;
    logic [15:0] es, mk;
    ltf_src_type fs;
    n = 0;
    seen = 1'b0;
    lay = 1'b0;
    // wait an edge so the caller's new cfg and cmd have landed
    @(posedge sys_clk);
    lg = cfg.mode == MODE_LEGACY;
    fs = (lg || cfg.flexible_model_flag &&
      cmd.command_byte_count == COUNT_ZERO) ? SRC_BUFFER : SRC_BLOCK;
    mk = k == 6 ? 16'hFFF0 : 16'hFFFF;
    case (k)
      1, 9: es = 16'h0100;
      2: es = 16'h0200;
      3: es = 16'h0400;
      4: es = 16'h1000;
      5: es = 16'h0020 + 16'(cfg.max_retry) + 16'h0001;
      7: es = 16'h2080;
      8: es = 16'h2040;
      default: es = 16'h2000;
    endcase
    collision_detect_input <= k == 8;
    col_mode <= k == 5 ? 2'h1 : k == 6 ? 2'h2 : 2'h0;
    @(posedge sys_clk);
    collision_detect_input <= 1'b0;
    cmd_start <= 1'b1;
    link_busy <= k == 7;
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    while (status_write !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
      if (n == 12)
        link_busy <= 1'b0;
      {cu_abort, crs_lost, cts_lost, data_underrun} <=
        (k >= 1 && k <= 4 && n == 150) ? 4'h1 << (k - 1) : 4'h0;
      #1;
      if (jam_active === 1'b1)
        seen = 1'b1;
      if (tx_active === 1'b1 && !lay)
      begin
        lay = 1'b1;
        chk("layout", {first_src, block_len, desc_addr},
          {fs, lg ? COUNT_ZERO : cmd.command_byte_count,
          cfg.mode == MODE_LINEAR ? cmd.desc_ptr : {16'h0, cmd.desc_ptr[15:0]}});
      end
    end
    chk("wait", n < 3000, 1'b1);
    chk("status", status_word & mk, es);
    chk("jam", seen, k >= 1 && k <= 5);
    chk("started", lay, k != 9);
  endtask : go
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      repeat (3)
      begin
        rnd = lf(rnd);
        r = {r[31:0], rnd};
      end
      cfg <= '{ltf_mode_type'(i % 10 == 9 ? 0 : r[1:0] % 3), r[2], r[3],
        r[4], 4'h2};
      cmd <= '{r[9:8] == 2'h0 ? NO_DESC_PTR : r[31:0],
        r[11:10] == 2'h0 ? COUNT_ZERO : r[29:16],
        r[14:12] == 3'h0 ? 48'hFFFF_FFFF_FFFF : r, r[47:32],
        i % 10 == 9 ? 14'h0003 : {4'h0, r[41:32]} | 14'h0040};
      go(i % 10);
    end
    @(posedge sys_clk);
    rst <= 1'b1;
    // last command was a short legacy frame; give this one a real length
    cmd.first_buf_count <= 14'h0100;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    go(0);
    wrap_up();
  end
  initial
  begin
    #300000;
    bad_count++;
    wrap_up();
  end
endmodule : tb_lan_transmit_frame_assembly

bind ltf_tx_assembly ltf_tx_monitor u_ltf_tx_monitor
(
  .sys_clk(sys_clk),
  .rst(rst),
  .cfg(cfg),
  .cmd(cmd),
  .collision(collision),
  .frame_last_bits(frame_last_bits),
  .tx_active(tx_active),
  .jam_active(jam_active),
  .insert_src_addr(insert_src_addr),
  .block_ofs(block_ofs),
  .use_desc(use_desc),
  .dest_group(dest_group),
  .dest_broadcast(dest_broadcast),
  .len_wire_order(len_wire_order),
  .status_word(status_word),
  .status_write(status_write)
);
